/* core/aow_cfg.svh */
// constants for the analog output waveform timing block
// assumes a single 20 MHz clock and an Avalon-MM register slave
//
// Function
// - pin 5 as output drives sample tick; falling edge marks new sample
// - pin 6 as output drives start trigger; rising edge starts generation
// - pin 6 is the default start trigger source
// - pin 8 default counter 0 source; as output shows selected source
// - pin 9 default counter 0 gate; as output shows selected gate
// - pins 8, 9 and counter 0 out inputs routable onto sync bus
// - counter 0 out pin as output carries counter 0 internal output
// - counter 1 out pin always carries counter 1 internal output
// - each sample tick every converter takes one sample and updates; if the buffer runs empty first, none updates
// - buffer keeps first-in-first-out order; preload allowed
// - per-channel reference select: internal +-10 V or external input
// - converter codes are 16 bits wide
// - one sample tick updates all channels together
// - pin 6 resets as input; output is active-high start pulse
`ifndef AOW_CFG_SVH
`define AOW_CFG_SVH

`define AOW_REG_CTRL       4'h0
`define AOW_REG_PINDIR     4'h1
`define AOW_REG_SRCSEL     4'h2
`define AOW_REG_REFSEL     4'h3
`define AOW_REG_DIVIDER    4'h4
`define AOW_REG_FIFO       4'h5
`define AOW_REG_STATUS     4'h6
`define AOW_REG_SYNCROUTE  4'h7

`define AOW_CTRL_ARM       0
`define AOW_CTRL_SWSTART   1
`define AOW_CTRL_STOP      2
`define AOW_CTRL_CLRERR    3
`define AOW_CTRL_EXTCLK    4

`define AOW_DIR_P5         0
`define AOW_DIR_P6         1
`define AOW_DIR_P8         2
`define AOW_DIR_P9         3
`define AOW_DIR_C0         4

`define AOW_DIV_RESET      16'h0013
`define AOW_PULSE_CYCLES   2

`endif

/* core/aow_pkg.sv */
// types for the analog output waveform timing block
// assumes nothing beyond standard systemverilog
package aow_pkg;
  typedef enum logic [1:0] {
    AOW_IDLE,
    AOW_ARMED,
    AOW_RUN
  } aow_state_t;

  typedef logic [15:0] aow_code_t;

  // start trigger source choice
  typedef enum logic [1:0] {
    AOW_TRG_PIN6,
    AOW_TRG_PIN5,
    AOW_TRG_SYNC0,
    AOW_TRG_SOFT
  } aow_trg_src_t;
endpackage

/* core/aow_fifo_if.sv */
// push and pop channel between top and sample buffer
// assumes one clock shared by both ends
interface aow_fifo_if #(parameter int WIDTH = 16);
  logic             push;
  logic [WIDTH-1:0] push_data;
  logic             full;
  logic             pop;
  logic [WIDTH-1:0] pop_data;
  logic             empty;
  logic             flush;
  modport buf_end (input push, push_data, pop, flush, output full, pop_data, empty);
  modport user    (output push, push_data, pop, flush, input full, pop_data, empty);
endinterface

/* core/aow_sync.sv */
// two-stage synchroniser with edge detect on the synced level
// assumes async input and one clock
module aow_sync (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~last_q;
  assign fall_out  = ~sync_q & last_q;
endmodule // aow_sync

/* core/aow_fifo.sv */
// sample buffer, first in first out
// assumes push never while full and pop never while empty
module aow_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64
) (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  aow_fifo_if.buf_end fif
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [WIDTH-1:0] out_q;
  wire              do_push = fif.push & ~fif.full;
  wire              do_pop  = fif.pop & ~fif.empty;

  assign fif.full     = (cnt_q == (AW+1)'(DEPTH));
  assign fif.empty    = (cnt_q == '0);
  assign fif.pop_data = mem[rd_q];

  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      mem[wr_q] <= fif.push_data;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (fif.flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // aow_fifo

/* core/aow_top.sv */
// analog output waveform timing and pin routing, Avalon-MM slave
// assumes pins arrive asynchronously; converters latch codes on each sample
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`include "aow_cfg.svh"
module aow_top #(
  parameter int CHANNELS = 2,
  parameter int DEPTH    = 64
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic [3:0]             avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out,
  input  wire logic                   prog_pin_5_in,
  output logic                        prog_pin_5_out,
  output logic                        prog_pin_5_oe_out,
  input  wire logic                   prog_pin_6_in,
  output logic                        prog_pin_6_out,
  output logic                        prog_pin_6_oe_out,
  input  wire logic                   prog_pin_8_in,
  output logic                        prog_pin_8_out,
  output logic                        prog_pin_8_oe_out,
  input  wire logic                   prog_pin_9_in,
  output logic                        prog_pin_9_out,
  output logic                        prog_pin_9_oe_out,
  input  wire logic                   cnt0_pin_in,
  output logic                        cnt0_pin_out,
  output logic                        cnt0_pin_oe_out,
  output logic                        cnt1_pin_out,
  input  wire logic                   cnt0_internal_out_in,
  input  wire logic                   cnt1_internal_out_in,
  input  wire logic                   cnt0_alt_source_in,
  input  wire logic                   cnt0_alt_gate_in,
  output logic                        cnt0_source_sel_out,
  output logic                        cnt0_gate_sel_out,
  input  wire logic [3:0]             sync_trigger_bus_in,
  output logic [3:0]                  sync_trigger_bus_out,
  output logic [3:0]                  sync_trigger_bus_oe_out,
  output logic [CHANNELS*16-1:0]      dac_code_out,
  output logic                        dac_update_out,
  output logic [CHANNELS-1:0]         ext_ref_sel_out
);
  localparam int CW = $clog2(CHANNELS + 1);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic p5_lvl, p5_rise, p5_fall;
  logic p6_lvl, p6_rise;
  logic p8_lvl, p9_lvl, c0_lvl, s0_rise;

  aow_sync u_s5 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .async_in(prog_pin_5_in),
                 .level_out(p5_lvl), .rise_out(p5_rise), .fall_out(p5_fall));
  aow_sync u_s6 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .async_in(prog_pin_6_in),
                 .level_out(p6_lvl), .rise_out(p6_rise), .fall_out());
  aow_sync u_s8 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .async_in(prog_pin_8_in),
                 .level_out(p8_lvl), .rise_out(), .fall_out());
  aow_sync u_s9 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .async_in(prog_pin_9_in),
                 .level_out(p9_lvl), .rise_out(), .fall_out());
  aow_sync u_sc (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .async_in(cnt0_pin_in),
                 .level_out(c0_lvl), .rise_out(), .fall_out());
  aow_sync u_sb (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .async_in(sync_trigger_bus_in[0]),
                 .level_out(), .rise_out(s0_rise), .fall_out());

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0]           dir_q;
  logic [5:0]           srcsel_q;
  logic [CHANNELS-1:0]  refsel_q;
  logic [15:0]          div_q;
  logic                 extclk_q;
  logic                 underflow_q;
  logic [11:0]          route_q;
  logic                 rd_pend_q;
  logic [31:0]          rdata_q;
  aow_pkg::aow_state_t  state_q;

  wire wr_ctrl   = avs_write_in & (avs_address_in == `AOW_REG_CTRL);
  wire wr_dir    = avs_write_in & (avs_address_in == `AOW_REG_PINDIR);
  wire wr_src    = avs_write_in & (avs_address_in == `AOW_REG_SRCSEL);
  wire wr_ref    = avs_write_in & (avs_address_in == `AOW_REG_REFSEL);
  wire wr_div    = avs_write_in & (avs_address_in == `AOW_REG_DIVIDER);
  wire wr_route  = avs_write_in & (avs_address_in == `AOW_REG_SYNCROUTE);

  aow_fifo_if #(.WIDTH(16)) fif ();
  wire wr_fifo   = avs_write_in & (avs_address_in == `AOW_REG_FIFO);

  wire ctl_arm    = wr_ctrl & avs_writedata_in[`AOW_CTRL_ARM];
  wire ctl_swst   = wr_ctrl & avs_writedata_in[`AOW_CTRL_SWSTART];
  wire ctl_stop   = wr_ctrl & avs_writedata_in[`AOW_CTRL_STOP];
  wire ctl_clrerr = wr_ctrl & avs_writedata_in[`AOW_CTRL_CLRERR];

  // buffer write accepted unless buffer full, other writes at once; read answers one cycle late
  assign avs_waitrequest_out = (wr_fifo & fif.full) | (avs_read_in & ~rd_pend_q);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dir_q    <= '0;
      srcsel_q <= '0;
      refsel_q <= '0;
      div_q    <= `AOW_DIV_RESET;
      extclk_q <= 1'b0;
      route_q  <= '0;
    end else begin
      if (wr_dir)   dir_q    <= avs_writedata_in[4:0];
      if (wr_src)   srcsel_q <= avs_writedata_in[5:0];
      if (wr_ref)   refsel_q <= avs_writedata_in[CHANNELS-1:0];
      if (wr_div)   div_q    <= avs_writedata_in[15:0];
      if (wr_ctrl)  extclk_q <= avs_writedata_in[`AOW_CTRL_EXTCLK];
      if (wr_route) route_q  <= avs_writedata_in[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start trigger selection
  aow_pkg::aow_trg_src_t trg_sel;
  logic trg_edge;
  assign trg_sel = aow_pkg::aow_trg_src_t'(srcsel_q[1:0]);

  always_comb begin
    unique case (trg_sel)
      aow_pkg::AOW_TRG_PIN6:  trg_edge = p6_rise;
      aow_pkg::AOW_TRG_PIN5:  trg_edge = p5_rise;
      aow_pkg::AOW_TRG_SYNC0: trg_edge = s0_rise;
      aow_pkg::AOW_TRG_SOFT:  trg_edge = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // generation state and sample tick
  logic [15:0] div_cnt_q;
  logic        tick_lvl_q;
  logic        start_ev;
  logic        sample_ev;
  logic [1:0]  pulse_cnt_q;
  assign start_ev  = (state_q == aow_pkg::AOW_ARMED) & (trg_edge | ctl_swst);
  wire   int_tick  = (state_q == aow_pkg::AOW_RUN) & (div_cnt_q == '0) & tick_lvl_q;
  assign sample_ev = extclk_q ? ((state_q == aow_pkg::AOW_RUN) & p5_fall) : int_tick;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= aow_pkg::AOW_IDLE;
    end else begin
      unique case (state_q)
        aow_pkg::AOW_IDLE:  if (ctl_arm) state_q <= aow_pkg::AOW_ARMED;
        aow_pkg::AOW_ARMED: if (ctl_stop) state_q <= aow_pkg::AOW_IDLE;
                            else if (start_ev) state_q <= aow_pkg::AOW_RUN;
        aow_pkg::AOW_RUN:   if (ctl_stop) state_q <= aow_pkg::AOW_IDLE;
        default:            state_q <= aow_pkg::AOW_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt_q  <= '0;
      tick_lvl_q <= 1'b0;
    end else if (state_q != aow_pkg::AOW_RUN) begin
      div_cnt_q  <= div_q;
      tick_lvl_q <= 1'b0;
    end else if (div_cnt_q == '0) begin
      div_cnt_q  <= div_q;
      tick_lvl_q <= ~tick_lvl_q;
    end else begin
      div_cnt_q  <= div_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_cnt_q <= '0;
    end else if (start_ev) begin
      pulse_cnt_q <= 2'(`AOW_PULSE_CYCLES);
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer and converter codes
  logic [CW-1:0]       ch_q;
  logic                busy_q;
  logic [CHANNELS*16-1:0] stage_q;
  logic                upd_q;

  aow_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .fif(fif)
  );

  // host writes enter buffer in order
  assign fif.push      = wr_fifo & ~fif.full;
  assign fif.push_data = avs_writedata_in[15:0];
  assign fif.flush     = ctl_stop;
  assign fif.pop       = busy_q & ~fif.empty;

  // one sample per channel per tick
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ch_q    <= '0;
      busy_q  <= 1'b0;
      stage_q <= '0;
      upd_q   <= 1'b0;
      underflow_q <= 1'b0;
    end else begin
      upd_q <= 1'b0;
      if (sample_ev & ~busy_q) begin
        busy_q <= 1'b1;
        ch_q   <= '0;
      end else if (busy_q) begin
        if (fif.empty) begin
          busy_q      <= 1'b0;
        end else begin
          stage_q[ch_q*16 +: 16] <= fif.pop_data;
          ch_q <= ch_q + 1'b1;
          if (ch_q == CW'(CHANNELS-1)) begin
            busy_q <= 1'b0;
            upd_q  <= 1'b1;
          end
        end
      end
      if (busy_q & fif.empty) begin
        underflow_q <= 1'b1;
      end else if (ctl_clrerr) begin
        underflow_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dac_code_out   <= '0;
      dac_update_out <= 1'b0;
    end else begin
      dac_update_out <= upd_q;
      if (upd_q) dac_code_out <= stage_q;
    end
  end

  assign ext_ref_sel_out = refsel_q;

  ////////////////////////////////////////////////////////////////////////
  // pin and counter routing
  // counter 0 source default pin 8
  assign cnt0_source_sel_out = srcsel_q[2] ? cnt0_alt_source_in : p8_lvl;
  // counter 0 gate default pin 9
  assign cnt0_gate_sel_out   = srcsel_q[3] ? cnt0_alt_gate_in : p9_lvl;

  assign prog_pin_5_oe_out = dir_q[`AOW_DIR_P5];
  assign prog_pin_6_oe_out = dir_q[`AOW_DIR_P6];
  assign prog_pin_8_oe_out = dir_q[`AOW_DIR_P8];
  assign prog_pin_9_oe_out = dir_q[`AOW_DIR_P9];
  assign cnt0_pin_oe_out   = dir_q[`AOW_DIR_C0];
  assign prog_pin_5_out    = ~extclk_q & tick_lvl_q;
  assign prog_pin_6_out    = (pulse_cnt_q != '0);
  assign prog_pin_8_out    = cnt0_source_sel_out;
  assign prog_pin_9_out    = cnt0_gate_sel_out;
  assign cnt0_pin_out      = cnt0_internal_out_in;
  assign cnt1_pin_out      = cnt1_internal_out_in;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_route
      assign sync_trigger_bus_out[g] = (route_q[g*3 +: 2] == 2'h0) ? p8_lvl :
                            (route_q[g*3 +: 2] == 2'h1) ? p9_lvl : c0_lvl;
      assign sync_trigger_bus_oe_out[g] = route_q[g*3+2] & (route_q[g*3 +: 2] != 2'h3);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read data
  logic [31:0] rd_mux;
  assign rd_mux =
    (avs_address_in == `AOW_REG_CTRL)      ? {27'h0, extclk_q, 4'h0} :
    (avs_address_in == `AOW_REG_PINDIR)    ? {27'h0, dir_q} :
    (avs_address_in == `AOW_REG_SRCSEL)    ? {26'h0, srcsel_q} :
    (avs_address_in == `AOW_REG_REFSEL)    ? {{(32-CHANNELS){1'b0}}, refsel_q} :
    (avs_address_in == `AOW_REG_DIVIDER)   ? {16'h0, div_q} :
    (avs_address_in == `AOW_REG_STATUS)    ? {26'h0, p6_lvl, p5_lvl, fif.full, fif.empty,
                                              underflow_q, state_q == aow_pkg::AOW_RUN} :
    (avs_address_in == `AOW_REG_SYNCROUTE) ? {20'h0, route_q} : 32'h0000_0000;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_pend_q <= 1'b0;
      rdata_q   <= '0;
    end else begin
      rd_pend_q <= avs_read_in & ~rd_pend_q;
      if (avs_read_in & ~rd_pend_q) rdata_q <= rd_mux;
    end
  end
  assign avs_readdata_out = rdata_q;
endmodule // aow_top

/* testbench/aow_top_monitor.sv */
// checker for the waveform timing block, top ports only
// assumes one clock and an active-low asynchronous reset
module aow_top_monitor #(
  parameter int CHANNELS = 2
) (
  input wire logic                    sys_clk_in,
  input wire logic                    reset_n_in,
  input wire logic                    prog_pin_5_out,
  input wire logic                    prog_pin_6_out,
  input wire logic                    prog_pin_6_oe_out,
  input wire logic                    prog_pin_8_in,
  input wire logic                    prog_pin_8_out,
  input wire logic                    prog_pin_8_oe_out,
  input wire logic                    prog_pin_9_out,
  input wire logic                    prog_pin_9_oe_out,
  input wire logic                    cnt0_pin_out,
  input wire logic                    cnt0_pin_oe_out,
  input wire logic                    cnt1_pin_out,
  input wire logic                    cnt0_internal_out_in,
  input wire logic                    cnt1_internal_out_in,
  input wire logic                    cnt0_alt_source_in,
  input wire logic                    cnt0_source_sel_out,
  input wire logic                    cnt0_gate_sel_out,
  input wire logic [CHANNELS*16-1:0]  dac_code_out,
  input wire logic                    dac_update_out
);
  default clocking mon_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_cnt1_pin_follow: assert property (
    cnt1_pin_out == cnt1_internal_out_in)
    else $error("counter 1 pin wrong");
  a_cnt0_pin_follow: assert property (
    cnt0_pin_oe_out |-> cnt0_pin_out == cnt0_internal_out_in)
    else $error("counter 0 pin wrong");
  a_pin8_shows_source: assert property (
    prog_pin_8_oe_out |-> prog_pin_8_out == cnt0_source_sel_out)
    else $error("pin 8 not source");
  a_pin9_shows_gate: assert property (
    prog_pin_9_oe_out |-> prog_pin_9_out == cnt0_gate_sel_out)
    else $error("pin 9 not gate");
  a_pin6_reset_input: assert property (
    $rose(reset_n_in) |-> !prog_pin_6_oe_out)
    else $error("pin 6 driven after reset");
  a_start_pulse_two: assert property (
    $rose(prog_pin_6_out) |=> prog_pin_6_out ##1 !prog_pin_6_out)
    else $error("start pulse width");
  a_codes_on_update: assert property (
    !dac_update_out |-> $stable(dac_code_out))
    else $error("codes moved without update");
  a_update_tick_low: assert property (
    dac_update_out |-> !prog_pin_5_out)
    else $error("update with tick high");
  a_tick_low_hold: assert property (
    $fell(prog_pin_5_out) |-> !prog_pin_5_out [*4])
    else $error("tick low too short");
  a_source_synced: assert property (
    $rose(cnt0_source_sel_out) |-> $past(prog_pin_8_in, 2) || $past(prog_pin_8_in, 3)
      || $past(cnt0_alt_source_in) || cnt0_alt_source_in)
    else $error("source rose without cause");
endmodule // aow_top_monitor

bind aow_top aow_top_monitor #(.CHANNELS(CHANNELS)) aow_top_monitor_inst (
  .sys_clk_in, .reset_n_in, .prog_pin_5_out, .prog_pin_6_out, .prog_pin_6_oe_out, .prog_pin_8_in,
  .prog_pin_8_out, .prog_pin_8_oe_out, .prog_pin_9_out, .prog_pin_9_oe_out, .cnt0_pin_out,
  .cnt0_pin_oe_out, .cnt1_pin_out, .cnt0_internal_out_in, .cnt1_internal_out_in, .cnt0_alt_source_in,
  .cnt0_source_sel_out, .cnt0_gate_sel_out, .dac_code_out, .dac_update_out);

/* testbench/aow_host_model.sv */
// host side model: avalon-mm master for registers and sample loading
// assumes a slave with combinational waitrequest on the same clock
module aow_host_model (
  input wire logic         sys_clk_in,
  output logic [3:0]       avs_address_out,
  output logic             avs_read_out,
  output logic             avs_write_out,
  output logic [31:0]      avs_writedata_out,
  input wire logic [31:0]  avs_readdata_in,
  input wire logic         avs_waitrequest_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int timeouts = 0;

  initial begin
    avs_address_out = 4'h0;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 32'h0;
  end

  task automatic wait_ack();
    int n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (avs_waitrequest_in !== 1'b0 && n < 200);
    if (avs_waitrequest_in !== 1'b0) timeouts++;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    avs_address_out <= a;
    avs_writedata_out <= d;
    avs_write_out <= 1'b1;
    wait_ack();
    avs_write_out <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    avs_address_out <= a;
    avs_read_out <= 1'b1;
    wait_ack();
    d = avs_readdata_in;
    avs_read_out <= 1'b0;
  endtask

  task automatic load_words(input logic [15:0] w[$]);
    foreach (w[i]) bus_write(4'h5, {16'h0000, w[i]});
  endtask
endmodule // aow_host_model

/* testbench/aow_waveform_fifo_timing_bench.sv */
// self-checking bench for the waveform timing block
// assumes aow_top, the host model and the bound checker
module aow_waveform_fifo_timing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CH = 2;
  logic sys_clk_in, reset_n_in, p5_drv, p6_drv, p8_drv, p9_drv, c0_drv;
  logic cnt0_internal_out_in, cnt1_internal_out_in, cnt0_alt_source_in, cnt0_alt_gate_in;
  logic [3:0] avs_address_in, sync_trigger_bus_in, sync_trigger_bus_out, sync_trigger_bus_oe_out;
  logic avs_read_in, avs_write_in, avs_waitrequest_out, dac_update_out, cnt1_pin_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, d;
  logic prog_pin_5_out, prog_pin_5_oe_out, prog_pin_6_out, prog_pin_6_oe_out;
  logic prog_pin_8_out, prog_pin_8_oe_out, prog_pin_9_out, prog_pin_9_oe_out;
  logic cnt0_pin_out, cnt0_pin_oe_out, cnt0_source_sel_out, cnt0_gate_sel_out;
  logic [CH*16-1:0] dac_code_out;
  logic [CH-1:0] ext_ref_sel_out;
  logic [CH*16-1:0] got_q[$];
  aow_pkg::aow_code_t wav[$] = '{16'h1234, 16'hFFFF, 16'h0000, 16'h8001, 16'h7FFE, 16'h00A5, 16'h5A5A, 16'hC3C3};
  int mismatches = 0;
  int total_checks = 0;
  int hi;
  wire logic prog_pin_5_in = prog_pin_5_oe_out ? prog_pin_5_out : p5_drv;
  wire logic prog_pin_6_in = prog_pin_6_oe_out ? prog_pin_6_out : p6_drv;
  wire logic prog_pin_8_in = prog_pin_8_oe_out ? prog_pin_8_out : p8_drv;
  wire logic prog_pin_9_in = prog_pin_9_oe_out ? prog_pin_9_out : p9_drv;
  wire logic cnt0_pin_in = cnt0_pin_oe_out ? cnt0_pin_out : c0_drv;

  aow_top #(.CHANNELS(CH), .DEPTH(64)) aow_top_inst (
    .sys_clk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .prog_pin_5_in, .prog_pin_5_out, .prog_pin_5_oe_out,
    .prog_pin_6_in, .prog_pin_6_out, .prog_pin_6_oe_out, .prog_pin_8_in, .prog_pin_8_out,
    .prog_pin_8_oe_out, .prog_pin_9_in, .prog_pin_9_out, .prog_pin_9_oe_out, .cnt0_pin_in,
    .cnt0_pin_out, .cnt0_pin_oe_out, .cnt1_pin_out, .cnt0_internal_out_in, .cnt1_internal_out_in,
    .cnt0_alt_source_in, .cnt0_alt_gate_in, .cnt0_source_sel_out, .cnt0_gate_sel_out,
    .sync_trigger_bus_in, .sync_trigger_bus_out, .sync_trigger_bus_oe_out, .dac_code_out,
    .dac_update_out, .ext_ref_sel_out);
  aow_host_model aow_host_model_inst (.sys_clk_in, .avs_address_out(avs_address_in),
    .avs_read_out(avs_read_in), .avs_write_out(avs_write_in), .avs_writedata_out(avs_writedata_in),
    .avs_readdata_in(avs_readdata_out), .avs_waitrequest_in(avs_waitrequest_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) if (reset_n_in && dac_update_out === 1'b1) got_q.push_back(dac_code_out);
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic guard(input logic ok, input string what);
    if (!ok) begin
      mismatches++;
      $display("MISMATCH at %0t: timed out on %s", $time, what);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    aow_host_model_inst.bus_write(a, v);
    guard(aow_host_model_inst.timeouts == 0, "bus write");
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    aow_host_model_inst.bus_read(a, v);
    guard(aow_host_model_inst.timeouts == 0, "bus read");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic wait_updates(input int n);
    int k = 0;
    while (got_q.size() < n && k < 3000) begin
      @(posedge sys_clk_in);
      k++;
    end
    guard(got_q.size() >= n, "converter update");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    reset_n_in = 1'b0;
    {p5_drv, p6_drv, p8_drv, p9_drv, c0_drv} = 5'h00;
    {cnt0_internal_out_in, cnt1_internal_out_in, cnt0_alt_source_in, cnt0_alt_gate_in} = 4'h0;
    sync_trigger_bus_in = 4'h0;
    cyc(2);
    reset_n_in <= 1'b1;
    rd(4'h4, d); chk(d, 32'h0000_0013, "divider reset");
    rd(4'h1, d); chk(d, 32'h0000_0000, "direction reset");
    wr(4'h3, 32'h0000_0002);
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC, d); chk(d, 32'h0000_0000, "unmapped read");
    rd(4'h3, d); chk(d, 32'h0000_0002, "reference readback");
    chk(ext_ref_sel_out, 32'h2, "reference select");
    $display("test registers done");
    cnt0_internal_out_in <= 1'b1;
    cnt1_internal_out_in <= 1'b1;
    p8_drv <= 1'b1;
    p9_drv <= 1'b1;
    wr(4'h1, 32'h0000_0010);
    cyc(5);
    chk(cnt1_pin_out, 32'h1, "counter 1 pin");
    chk({cnt0_pin_oe_out, cnt0_pin_out}, 32'h3, "counter 0 pin");
    chk(cnt0_source_sel_out, 32'h1, "default source");
    chk(cnt0_gate_sel_out, 32'h1, "default gate");
    cnt0_alt_source_in <= 1'b1;
    wr(4'h2, 32'h0000_000C);
    wr(4'h1, 32'h0000_001C);
    cyc(5);
    chk({prog_pin_8_oe_out, prog_pin_8_out}, 32'h3, "pin 8 shows source");
    chk({prog_pin_9_oe_out, prog_pin_9_out}, 32'h2, "pin 9 shows gate");
    cnt0_alt_gate_in <= 1'b1;
    cyc(3);
    chk(prog_pin_9_out, 32'h1, "pin 9 follows gate");
    wr(4'h1, 32'h0000_0000);
    wr(4'h2, 32'h0000_0000);
    wr(4'h7, 32'h0000_01AC);
    for (int i = 0; i < 2; i++) begin
      {p8_drv, p9_drv, c0_drv} <= (i == 0) ? 3'b101 : 3'b010;
      cyc(6);
      chk(sync_trigger_bus_out[2:0], (i == 0) ? 32'h5 : 32'h2, "sync bus route");
      chk(sync_trigger_bus_oe_out, 32'h7, "sync bus enables");
    end
    wr(4'h7, 32'h0000_0000);
    $display("test pins done");
    wr(4'h4, 32'h0000_0007);
    wr(4'h1, 32'h0000_0001);
    aow_host_model_inst.load_words(wav[0:5]);
    rd(4'h6, d); chk(d[3:0], 32'h0, "preloaded status");
    wr(4'h0, 32'h0000_0001);
    p6_drv <= 1'b1;
    wait_updates(3);
    for (int k = 0; k < 3; k++) chk(got_q[k], {wav[2*k+1], wav[2*k]}, "sample order");
    cyc(60);
    rd(4'h6, d); chk(d[1], 32'h1, "underflow flag");
    chk(got_q.size(), 32'h3, "no update on empty");
    chk(dac_code_out, {wav[5], wav[4]}, "codes held");
    wr(4'h0, 32'h0000_0004);
    wr(4'h0, 32'h0000_0008);
    rd(4'h6, d); chk(d[1], 32'h0, "underflow cleared");
    p6_drv <= 1'b0;
    $display("test generation done");
    wr(4'h1, 32'h0000_0003);
    wr(4'h2, 32'h0000_0003);
    aow_host_model_inst.load_words(wav[6:7]);
    wr(4'h0, 32'h0000_0001);
    wr(4'h0, 32'h0000_0002);
    hi = 0;
    repeat (20) begin
      @(posedge sys_clk_in);
      if (prog_pin_6_out === 1'b1) hi++;
    end
    chk(hi, 32'h2, "start pulse width");
    chk(prog_pin_6_oe_out, 32'h1, "pin 6 drives");
    wait_updates(4);
    chk(got_q[3], {wav[7], wav[6]}, "software start sample");
    wr(4'h0, 32'h0000_0004);
    $display("test start pulse done");
    report_and_stop();
  end
endmodule // aow_waveform_fifo_timing_bench
